//--- logic/rcm_pkg.sv
// constants and types shared by the configuration module loader
package rcm_pkg;

  // clock and interval timing
  localparam int unsigned RCM_CLK_HZ        = 100_000_000;
  localparam int unsigned RCM_HOLD_S        = 3;
  localparam int unsigned RCM_HOLD_CYC      = RCM_HOLD_S * RCM_CLK_HZ;
  localparam int unsigned RCM_FAST_HALF_MS  = 50;
  localparam int unsigned RCM_FAST_HALF_CYC = RCM_FAST_HALF_MS * (RCM_CLK_HZ / 1000);
  localparam int unsigned RCM_SLOW_PER_FAST = 5;

  // port widths
  localparam int unsigned RCM_NUM_OUT = 2;
  localparam int unsigned RCM_NUM_IN  = 8;
  localparam int unsigned RCM_VAL_W   = 16;

  // factory default settings
  localparam int unsigned       RCM_BYPASS_LIMIT_S = 1;
  localparam int unsigned       RCM_DELAY_OUT_MS   = 100;
  localparam int unsigned       RCM_MUTE_LIMIT_S   = 30;
  localparam logic [15:0]       RCM_BYPASS_DEF_MS  = 16'(RCM_BYPASS_LIMIT_S * 1000);
  localparam logic [15:0]       RCM_DELAY_DEF_MS   = 16'(RCM_DELAY_OUT_MS);
  localparam logic [15:0]       RCM_MUTE_DEF_S     = 16'(RCM_MUTE_LIMIT_S);
  localparam logic [31:0]       RCM_IP_DEF         = {8'hC0, 8'hA8, 8'h00, 8'h80};

  // loader states, one-hot
  typedef enum logic [11:0] {
    ST_BOOT     = 12'h001,
    ST_WAIT_CFG = 12'h002,
    ST_INS_FAST = 12'h004,
    ST_DOWNLOAD = 12'h008,
    ST_WAIT_PWR = 12'h010,
    ST_CFG_IDLE = 12'h020,
    ST_COMPARE  = 12'h040,
    ST_MATCH    = 12'h080,
    ST_NETWR    = 12'h100,
    ST_MATCHED  = 12'h200,
    ST_MISMATCH = 12'h400,
    ST_LOCKOUT  = 12'h800
  } rcm_state_t;

endpackage

//--- logic/rcm_tick_if.sv
// interval timer and blink carrier between loader and timer
`timescale 1ns/10ps
interface rcm_tick_if;
  logic start;
  logic done;
  logic fast;
  logic slow;

  modport tmr (input start, output done, output fast, output slow);
  modport ctl (output start, input done, input fast, input slow);
endinterface // rcm_tick_if

//--- logic/rcm_timer.sv
// three-second interval timer and indicator blink dividers
`timescale 1ns/10ps
module rcm_timer import rcm_pkg::*; #(
  parameter int unsigned HOLD_CYC      = RCM_HOLD_CYC,
  parameter int unsigned FAST_HALF_CYC = RCM_FAST_HALF_CYC,
  parameter int unsigned SLOW_PER_FAST = RCM_SLOW_PER_FAST
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // timer and blink carrier
  rcm_tick_if.tmr  tk
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int DW = $clog2(FAST_HALF_CYC + 1);
  localparam int SW = $clog2(SLOW_PER_FAST + 1);

  typedef struct packed {
    logic          run;
    logic [HW-1:0] hold;
    logic          done;
    logic [DW-1:0] div;
    logic [SW-1:0] sub;
    logic          fast;
    logic          slow;
  } rcm_tmr_t;

  rcm_tmr_t r_reg;
  rcm_tmr_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    // a restart discards any interval already running
    if (tk.start) begin
      r_next.run  = 1'b1;
      r_next.hold = HW'(HOLD_CYC - 1);
    end else if (r_reg.run) begin
      if (r_reg.hold == '0) begin
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.hold = r_reg.hold - 1'b1;
      end
    end
    // one-cycle enable from the divider toggles the blink phases
    if (r_reg.div == DW'(FAST_HALF_CYC - 1)) begin
      r_next.div  = '0;
      r_next.fast = ~r_reg.fast;
      if (r_reg.sub == SW'(SLOW_PER_FAST - 1)) begin
        r_next.sub  = '0;
        r_next.slow = ~r_reg.slow;
      end else begin
        r_next.sub = r_reg.sub + 1'b1;
      end
    end else begin
      r_next.div = r_reg.div + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tk.done = r_reg.done;
  assign tk.fast = r_reg.fast;
  assign tk.slow = r_reg.slow;

  a_start_no_done: assert property (@(posedge mclk) disable iff (sys_rst)
    tk.start |=> !tk.done)
    else $error("interval done right after start");

endmodule // rcm_timer

//--- logic/rcm_loader.sv
// removable configuration module loader: detect, download, compare, lockout
// Summary of operation
// - unconfigured: power green, usb flashes green
// - configured, no module: power green, usb red
// - insert into unconfigured: fast flash, then download
// - download done: power flashes, await power cycle
// - all match: usb green flash, then steady
// - network differs, unlocked: write network settings
// - network differs, locked: no write, lockout
// - config or password mismatch: usb flashes red
// - mismatch not removed in 3 s: lockout
// - after power cycle: usb shows presence, io mirrors
// - factory reset needs primary user credential
// - default bypass time limit 1 s
// - default delay output 100 ms
// - default muting time limit 30 s
// - default address 192.168.0.128
// - lockout: outputs off until clear and reset
`timescale 1ns/10ps
module rcm_loader import rcm_pkg::*; #(
  parameter int unsigned NUM_OUT       = RCM_NUM_OUT,
  parameter int unsigned NUM_IN        = RCM_NUM_IN,
  parameter int unsigned HOLD_CYC      = RCM_HOLD_CYC,
  parameter int unsigned FAST_HALF_CYC = RCM_FAST_HALF_CYC,
  parameter int unsigned SLOW_PER_FAST = RCM_SLOW_PER_FAST
) (
  // clock and reset (reset is the power cycle)
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // stored configuration
  input  wire logic               cfg_stored,
  // configuration module
  input  wire logic               mod_present,
  input  wire logic               mod_locked,
  // comparison engine
  input  wire logic               cmp_valid,
  input  wire logic               cfg_match,
  input  wire logic               pwd_match,
  input  wire logic               net_match,
  // copy engine
  output logic                    dl_req,
  input  wire logic               dl_done,
  output logic                    netwr_req,
  input  wire logic               netwr_done,
  // lockout and system reset
  input  wire logic               ext_fault,
  input  wire logic               sysreset_btn,
  output logic                    lockout,
  // factory defaults
  input  wire logic               factory_req,
  input  wire logic               cred_ok,
  output logic                    defaults_load,
  output logic [RCM_VAL_W-1:0]    bypass_limit_ms,
  output logic [RCM_VAL_W-1:0]    delay_out_ms,
  output logic [RCM_VAL_W-1:0]    mute_limit_s,
  output logic [31:0]             ip_addr,
  // safety outputs and input indicators
  input  wire logic [NUM_OUT-1:0] safety_req,
  output logic [NUM_OUT-1:0]      safety_out,
  input  wire logic [NUM_IN-1:0]  in_state,
  output logic [NUM_IN-1:0]       io_led,
  // indicators
  output logic                    pwr_led_g,
  output logic                    pwr_led_r,
  output logic                    usb_led_g,
  output logic                    usb_led_r
);

  typedef struct packed {
    rcm_state_t           st;
    logic                 cfg;
    logic                 tmr_start;
    logic                 dl_req;
    logic                 netwr_req;
    logic                 lockout;
    logic                 defaults_load;
    logic [RCM_VAL_W-1:0] bypass;
    logic [RCM_VAL_W-1:0] delay;
    logic [RCM_VAL_W-1:0] mute;
    logic [31:0]          ip;
    logic [NUM_OUT-1:0]   safety_out;
    logic [NUM_IN-1:0]    io_led;
    logic                 pwr_g;
    logic                 pwr_r;
    logic                 usb_g;
    logic                 usb_r;
  } rcm_loader_t;

  rcm_loader_t r_reg;
  rcm_loader_t r_next;

  rcm_tick_if tk ();

  rcm_timer #(
    .HOLD_CYC      (HOLD_CYC),
    .FAST_HALF_CYC (FAST_HALF_CYC),
    .SLOW_PER_FAST (SLOW_PER_FAST)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tk      (tk)
  );

  assign tk.start = r_reg.tmr_start;

  // outputs may run only with a configuration in force and no lockout
  function automatic logic run_allowed(input rcm_state_t st, input logic cfg);
    run_allowed = cfg && (st != ST_LOCKOUT) && (st != ST_WAIT_PWR) && (st != ST_BOOT);
  endfunction

  always_comb begin
    r_next               = r_reg;
    r_next.tmr_start     = 1'b0;
    r_next.defaults_load = 1'b0;

    case (r_reg.st)
      // the stored-configuration level is caught after reset release
      ST_BOOT: begin
        r_next.cfg = cfg_stored;
        r_next.st  = cfg_stored ? ST_CFG_IDLE : ST_WAIT_CFG;
      end
      ST_WAIT_CFG: begin
        if (mod_present) begin
          r_next.st        = ST_INS_FAST;
          r_next.tmr_start = 1'b1;
        end
      end
      ST_INS_FAST: begin
        if (!mod_present) begin
          r_next.st = ST_WAIT_CFG;
        end else if (tk.done) begin
          r_next.st     = ST_DOWNLOAD;
          r_next.dl_req = 1'b1;
        end
      end
      ST_DOWNLOAD: begin
        if (dl_done) begin
          r_next.st     = ST_WAIT_PWR;
          r_next.dl_req = 1'b0;
        end else if (!mod_present) begin
          // a pulled module aborts the copy; the unit stays unconfigured
          r_next.st     = ST_WAIT_CFG;
          r_next.dl_req = 1'b0;
        end
      end
      ST_WAIT_PWR: begin
        // new configuration runs only after the next power cycle
        r_next.st = ST_WAIT_PWR;
      end
      ST_CFG_IDLE: begin
        if (ext_fault) begin
          r_next.st      = ST_LOCKOUT;
          r_next.lockout = 1'b1;
        end else if (mod_present) begin
          r_next.st = ST_COMPARE;
        end
      end
      ST_COMPARE: begin
        if (!mod_present) begin
          r_next.st = ST_CFG_IDLE;
        end else if (cmp_valid) begin
          r_next.tmr_start = 1'b1;
          if (!(cfg_match && pwd_match)) begin
            r_next.st = ST_MISMATCH;
          end else if (!net_match && mod_locked) begin
            r_next.st        = ST_LOCKOUT;
            r_next.lockout   = 1'b1;
            r_next.tmr_start = 1'b0;
          end else begin
            r_next.st = ST_MATCH;
          end
        end
      end
      ST_MATCH: begin
        if (!mod_present) begin
          r_next.st = ST_CFG_IDLE;
        end else if (tk.done) begin
          if (net_match) begin
            r_next.st = ST_MATCHED;
          end else if (mod_locked) begin
            // lock applied during the interval still forbids the write
            r_next.st      = ST_LOCKOUT;
            r_next.lockout = 1'b1;
          end else begin
            r_next.st        = ST_NETWR;
            r_next.netwr_req = 1'b1;
          end
        end
      end
      ST_NETWR: begin
        if (netwr_done || !mod_present) begin
          r_next.netwr_req = 1'b0;
          r_next.st        = mod_present ? ST_MATCHED : ST_CFG_IDLE;
        end
      end
      ST_MATCHED: begin
        if (ext_fault) begin
          r_next.st      = ST_LOCKOUT;
          r_next.lockout = 1'b1;
        end else if (!mod_present) begin
          r_next.st = ST_CFG_IDLE;
        end
      end
      ST_MISMATCH: begin
        if (!mod_present) begin
          r_next.st = ST_CFG_IDLE;
        end else if (tk.done) begin
          r_next.st      = ST_LOCKOUT;
          r_next.lockout = 1'b1;
        end
      end
      ST_LOCKOUT: begin
        // the causing module must be gone, or the lockout would recur
        if (!mod_present && !ext_fault && sysreset_btn) begin
          r_next.st      = ST_CFG_IDLE;
          r_next.lockout = 1'b0;
        end
      end
      default: begin
        r_next.st = ST_BOOT;
      end
    endcase

    // factory reset wipes the settings and leaves the unit unconfigured
    if (factory_req && cred_ok && (r_reg.st != ST_LOCKOUT) && (r_reg.st != ST_BOOT)) begin
      r_next.st            = ST_WAIT_CFG;
      r_next.cfg           = 1'b0;
      r_next.dl_req        = 1'b0;
      r_next.netwr_req     = 1'b0;
      r_next.tmr_start     = 1'b0;
      r_next.defaults_load = 1'b1;
      r_next.bypass        = RCM_BYPASS_DEF_MS;
      r_next.delay         = RCM_DELAY_DEF_MS;
      r_next.mute          = RCM_MUTE_DEF_S;
      r_next.ip            = RCM_IP_DEF;
    end

    r_next.safety_out = run_allowed(r_reg.st, r_reg.cfg) ? safety_req : '0;
    r_next.io_led     = in_state;

    // indicator pattern of the current state
    r_next.pwr_g = 1'b1;
    r_next.pwr_r = 1'b0;
    r_next.usb_g = 1'b0;
    r_next.usb_r = 1'b0;
    case (r_reg.st)
      ST_WAIT_CFG: r_next.usb_g = tk.slow;
      ST_INS_FAST: r_next.usb_g = tk.fast;
      ST_DOWNLOAD: r_next.usb_g = 1'b1;
      ST_WAIT_PWR: begin
        r_next.pwr_g = tk.slow;
        r_next.usb_g = 1'b1;
      end
      ST_CFG_IDLE: r_next.usb_r = 1'b1;
      ST_COMPARE:  r_next.usb_r = 1'b1;
      ST_MATCH:    r_next.usb_g = tk.slow;
      ST_NETWR:    r_next.usb_g = 1'b1;
      ST_MATCHED:  r_next.usb_g = 1'b1;
      ST_MISMATCH: r_next.usb_r = tk.slow;
      ST_LOCKOUT: begin
        r_next.pwr_g = 1'b0;
        r_next.pwr_r = tk.slow;
        r_next.usb_r = tk.slow;
      end
      default: r_next.pwr_g = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_reg        <= '0;
      r_reg.st     <= ST_BOOT;
      r_reg.bypass <= RCM_BYPASS_DEF_MS;
      r_reg.delay  <= RCM_DELAY_DEF_MS;
      r_reg.mute   <= RCM_MUTE_DEF_S;
      r_reg.ip     <= RCM_IP_DEF;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dl_req          = r_reg.dl_req;
  assign netwr_req       = r_reg.netwr_req;
  assign lockout         = r_reg.lockout;
  assign defaults_load   = r_reg.defaults_load;
  assign bypass_limit_ms = r_reg.bypass;
  assign delay_out_ms    = r_reg.delay;
  assign mute_limit_s    = r_reg.mute;
  assign ip_addr         = r_reg.ip;
  assign safety_out      = r_reg.safety_out;
  assign io_led          = r_reg.io_led;
  assign pwr_led_g       = r_reg.pwr_g;
  assign pwr_led_r       = r_reg.pwr_r;
  assign usb_led_g       = r_reg.usb_g;
  assign usb_led_r       = r_reg.usb_r;

  a_wait_cfg_leds: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_WAIT_CFG) && !factory_req |=> pwr_led_g && !pwr_led_r && (usb_led_g == $past(tk.slow)))
    else $error("unconfigured indicator pattern wrong");

  a_idle_usb_red: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_CFG_IDLE) |=> pwr_led_g && usb_led_r && !usb_led_g)
    else $error("configured idle indicator pattern wrong");

  a_fast_then_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_INS_FAST) && mod_present && tk.done && !factory_req |=> dl_req ##1 usb_led_g)
    else $error("download not started after insertion interval");

  a_copy_done_wait: assert property (@(posedge mclk) disable iff (sys_rst)
    dl_req && dl_done && !factory_req |=> !dl_req && (r_reg.st == ST_WAIT_PWR) ##1 (pwr_led_g == $past(tk.slow)))
    else $error("download completion not followed by power-cycle wait");

  a_match_steady: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_MATCH) && mod_present && tk.done && net_match && !factory_req |=> ##1 usb_led_g)
    else $error("usb indicator not steady after match interval");

  a_net_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_MATCH) && mod_present && tk.done && !net_match && !mod_locked && !factory_req |=> netwr_req)
    else $error("network write not requested");

  a_locked_no_wr: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_COMPARE) && mod_present && cmp_valid && cfg_match && pwd_match && !net_match && mod_locked
      && !factory_req |=> lockout && !netwr_req)
    else $error("locked module not handled by lockout");

  a_mismatch_red: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_MISMATCH) && !factory_req |=> !usb_led_g && (usb_led_r == $past(tk.slow)))
    else $error("mismatch indicator pattern wrong");

  a_mismatch_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_MISMATCH) && mod_present && tk.done && !factory_req |=> lockout ##1 !pwr_led_g)
    else $error("mismatch interval expiry did not lock out");

  a_io_mirror: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> io_led == $past(in_state))
    else $error("input indicators do not follow inputs");

  a_cred_needed: assert property (@(posedge mclk) disable iff (sys_rst)
    factory_req && !cred_ok |=> !defaults_load)
    else $error("defaults loaded without credential");

  a_def_bypass: assert property (@(posedge mclk) disable iff (sys_rst)
    defaults_load |-> (bypass_limit_ms == RCM_BYPASS_DEF_MS) && $past(factory_req && cred_ok))
    else $error("bypass default wrong");

  a_def_delay: assert property (@(posedge mclk) disable iff (sys_rst)
    defaults_load |-> (delay_out_ms == RCM_DELAY_DEF_MS))
    else $error("delay default wrong");

  a_def_mute: assert property (@(posedge mclk) disable iff (sys_rst)
    defaults_load |-> (mute_limit_s == RCM_MUTE_DEF_S))
    else $error("muting default wrong");

  a_def_ip: assert property (@(posedge mclk) disable iff (sys_rst)
    defaults_load |-> (ip_addr == RCM_IP_DEF) && !lockout)
    else $error("address default wrong");

  a_lock_outs_off: assert property (@(posedge mclk) disable iff (sys_rst)
    lockout && $past(lockout) |-> (safety_out == '0))
    else $error("safety output on during lockout");

  a_lock_exit: assert property (@(posedge mclk) disable iff (sys_rst)
    lockout && !sysreset_btn && !factory_req |=> lockout)
    else $error("lockout left without system reset");

  a_tmr_started: assert property (@(posedge mclk) disable iff (sys_rst)
    (r_reg.st == ST_WAIT_CFG) && mod_present && !factory_req |=> tk.start && (r_reg.st == ST_INS_FAST))
    else $error("interval not started on insertion");

endmodule // rcm_loader

//--- verification/rcm_mod_model.sv
// partner model: removable configuration module with its compare and copy engines
`timescale 1ns/10ps
module rcm_mod_model (
  // clock
  mclk,
  // bench knobs
  plug,
  lock,
  cfg_eq,
  pwd_eq,
  net_eq,
  slow,
  // device side
  dl_req,
  netwr_req,
  mod_present,
  mod_locked,
  cmp_valid,
  cfg_match,
  pwd_match,
  net_match,
  dl_done,
  netwr_done
);
  input  wire logic mclk;
  input  wire logic plug;
  input  wire logic lock;
  input  wire logic cfg_eq;
  input  wire logic pwd_eq;
  input  wire logic net_eq;
  input  wire logic slow;
  input  wire logic dl_req;
  input  wire logic netwr_req;
  output logic      mod_present;
  output logic      mod_locked;
  output logic      cmp_valid;
  output logic      cfg_match;
  output logic      pwd_match;
  output logic      net_match;
  output logic      dl_done;
  output logic      netwr_done;

  typedef struct packed {
    logic [3:0] age;
    logic [3:0] busy;
    logic       net;
    logic       tog;
    logic       dl;
    logic       nw;
  } rcm_mm_t;

  rcm_mm_t st_reg = '0;
  rcm_mm_t st_next;

  // the image held is always a confirmed one; unconfirmed images never reach the model
  // lock and match lines of an absent module toggle so a stale value is never mistaken for a real one
  assign mod_present = plug;
  assign mod_locked  = plug ? lock : st_reg.tog;
  assign cmp_valid   = plug && (st_reg.age >= 4'h2);
  assign cfg_match   = plug ? cfg_eq : st_reg.tog;
  assign pwd_match   = plug ? pwd_eq : st_reg.tog;
  assign net_match   = plug ? st_reg.net : st_reg.tog;
  assign dl_done     = st_reg.dl;
  assign netwr_done  = st_reg.nw;

  always_comb begin
    st_next     = st_reg;
    st_next.tog = ~st_reg.tog;
    st_next.age = !plug ? 4'h0 : (st_reg.age == 4'hF ? 4'hF : st_reg.age + 4'h1);
    st_next.busy = (dl_req || netwr_req) ? st_reg.busy + 4'h1 : 4'h0;
    st_next.dl  = dl_req && (st_reg.busy == (slow ? 4'h6 : 4'h1));
    st_next.nw  = netwr_req && (st_reg.busy == (slow ? 4'h6 : 4'h1));
    if (!plug) begin
      st_next.net = net_eq;
    end else if (st_reg.nw) begin
      st_next.net = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end
endmodule // rcm_mod_model

//--- verification/rcm_loader_tb_top.sv
// self-checking bench for the configuration module loader
`timescale 1ns/10ps
module rcm_loader_tb_top;
  localparam int HOLD = 60;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cfg_stored = 1'b0;
  logic        plug = 1'b0;
  logic        lock = 1'b0;
  logic        cfg_eq = 1'b1;
  logic        pwd_eq = 1'b1;
  logic        net_eq = 1'b1;
  logic        slow = 1'b0;
  logic        ext_fault = 1'b0;
  logic        sysreset_btn = 1'b0;
  logic        factory_req = 1'b0;
  logic        cred_ok = 1'b0;
  logic [1:0]  safety_req = 2'h0;
  logic [7:0]  in_state = 8'h00;
  logic        mod_present, mod_locked, cmp_valid, cfg_match, pwd_match, net_match;
  logic        dl_req, dl_done, netwr_req, netwr_done, lockout, defaults_load;
  logic [15:0] bypass_limit_ms, delay_out_ms, mute_limit_s;
  logic [31:0] ip_addr;
  logic [1:0]  safety_out;
  logic [7:0]  io_led;
  logic        pwr_led_g, pwr_led_r, usb_led_g, usb_led_r;
  int          failures = 0;
  int          samples_checked = 0;
  int          k;

  rcm_loader #(.HOLD_CYC(HOLD), .FAST_HALF_CYC(2), .SLOW_PER_FAST(5)) u_rcm_loader (
    .mclk(mclk), .sys_rst(sys_rst), .cfg_stored(cfg_stored), .mod_present(mod_present),
    .mod_locked(mod_locked), .cmp_valid(cmp_valid), .cfg_match(cfg_match), .pwd_match(pwd_match),
    .net_match(net_match), .dl_req(dl_req), .dl_done(dl_done), .netwr_req(netwr_req),
    .netwr_done(netwr_done), .ext_fault(ext_fault), .sysreset_btn(sysreset_btn), .lockout(lockout),
    .factory_req(factory_req), .cred_ok(cred_ok), .defaults_load(defaults_load),
    .bypass_limit_ms(bypass_limit_ms), .delay_out_ms(delay_out_ms), .mute_limit_s(mute_limit_s),
    .ip_addr(ip_addr), .safety_req(safety_req), .safety_out(safety_out), .in_state(in_state),
    .io_led(io_led), .pwr_led_g(pwr_led_g), .pwr_led_r(pwr_led_r), .usb_led_g(usb_led_g),
    .usb_led_r(usb_led_r));

  rcm_mod_model u_rcm_mod_model (
    .mclk(mclk), .plug(plug), .lock(lock), .cfg_eq(cfg_eq), .pwd_eq(pwd_eq), .net_eq(net_eq),
    .slow(slow), .dl_req(dl_req), .netwr_req(netwr_req), .mod_present(mod_present),
    .mod_locked(mod_locked), .cmp_valid(cmp_valid), .cfg_match(cfg_match), .pwd_match(pwd_match),
    .net_match(net_match), .dl_done(dl_done), .netwr_done(netwr_done));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // each led pair of bits: 0 off, 1 blinking, 2 steady on
  task automatic leds(input string what, input logic [7:0] exp, input int n);
    int c [4];
    logic [7:0] cls;
    c = '{0, 0, 0, 0};
    repeat (n) begin
      @(negedge mclk);
      c[0] += int'(pwr_led_g === 1'b1);
      c[1] += int'(pwr_led_r === 1'b1);
      c[2] += int'(usb_led_g === 1'b1);
      c[3] += int'(usb_led_r === 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      cls[7-2*i -: 2] = (c[i] == 0) ? 2'h0 : (c[i] == n) ? 2'h2 : 2'h1;
    end
    chk(what, {24'h0, cls}, {24'h0, exp});
  endtask

  task automatic wait_sig(input int sel, input int lim, output int n);
    n = 0;
    while (n < lim && !((sel == 0 && dl_req === 1'b1) || (sel == 1 && netwr_req === 1'b1) ||
           (sel == 2 && lockout === 1'b1) || (sel == 3 && dl_req === 1'b0 && netwr_req === 1'b0))) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic power_cycle(input logic cfg);
    @(posedge mclk);
    sys_rst    <= 1'b1;
    cfg_stored <= cfg;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic t_unconfig();
    power_cycle(1'b0);
    leds("unconfigured", 8'h84, 40);
    @(posedge mclk);
    slow <= 1'b1;
    plug <= 1'b1;
    leds("insert_fast", 8'h84, 8);
    wait_sig(0, HOLD + 20, k);
    chk("dl_delay", int'(k >= HOLD - 14 && k <= HOLD), 1);
    wait_sig(3, 20, k);
    chk("dl_released", dl_req, 1'b0);
    leds("wait_power", 8'h48, 40);
    power_cycle(1'b1);
    repeat (HOLD + 20) @(posedge mclk);
    safety_req <= 2'h3;
    in_state   <= 8'hA5;
    leds("after_power", 8'h88, 40);
    chk("io_led", io_led, 8'hA5);
    chk("safety_out", safety_out, 2'h3);
  endtask

  task automatic exit_lock();
    @(posedge mclk);
    safety_req   <= 2'h3;
    plug         <= 1'b0;
    ext_fault    <= 1'b1;
    sysreset_btn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("lock_held", lockout, 1'b1);
    chk("safety_off", safety_out, 2'h0);
    ext_fault <= 1'b0;
    repeat (4) @(posedge mclk);
    sysreset_btn <= 1'b0;
    chk("lock_exit", lockout, 1'b0);
  endtask

  // the model latches network state only while unplugged, so it is set before insertion
  task automatic t_netwr(input logic lk);
    @(posedge mclk);
    plug   <= 1'b0;
    slow   <= 1'b0;
    net_eq <= 1'b0;
    lock   <= lk;
    power_cycle(1'b1);
    leds("no_module", 8'h82, 40);
    @(posedge mclk);
    plug   <= 1'b1;
    if (!lk) begin
      wait_sig(1, HOLD + 30, k);
      chk("netwr_delay", int'(k >= HOLD && k <= HOLD + 10), 1);
      wait_sig(3, 20, k);
      leds("net_written", 8'h88, 20);
    end else begin
      wait_sig(2, 12, k);
      chk("lock_locked", lockout, 1'b1);
      chk("no_netwr", netwr_req, 1'b0);
      leds("lock_leds", 8'h11, 40);
      exit_lock();
    end
    @(posedge mclk);
    net_eq <= 1'b1;
    lock   <= 1'b0;
  endtask

  task automatic t_mismatch(input logic hold);
    @(posedge mclk);
    plug   <= 1'b0;
    cfg_eq <= 1'b0;
    repeat (3) @(posedge mclk);
    plug <= 1'b1;
    leds("mismatch", 8'h81, 20);
    if (!hold) begin
      @(posedge mclk);
      plug <= 1'b0;
      repeat (HOLD + 10) @(posedge mclk);
      chk("removed_in_time", lockout, 1'b0);
    end else begin
      wait_sig(2, HOLD + 10, k);
      chk("mis_delay", int'(k >= HOLD - 22 && k <= HOLD - 10), 1);
      leds("mis_lock", 8'h11, 40);
      exit_lock();
    end
    cfg_eq <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // refused request first, then an accepted one with the credential
  task automatic t_defaults();
    @(posedge mclk);
    factory_req <= 1'b1;
    cred_ok     <= 1'b0;
    @(posedge mclk);
    factory_req <= 1'b0;
    repeat (3) begin
      @(negedge mclk);
      chk("refused", defaults_load, 1'b0);
    end
    @(posedge mclk);
    factory_req <= 1'b1;
    cred_ok     <= 1'b1;
    @(posedge mclk);
    factory_req <= 1'b0;
    cred_ok     <= 1'b0;
    @(negedge mclk);
    chk("defaults_load", defaults_load, 1'b1);
    chk("bypass", bypass_limit_ms, 16'h03E8);
    chk("delay", delay_out_ms, 16'h0064);
    chk("mute", mute_limit_s, 16'h001E);
    chk("ip", ip_addr, 32'hC0A80080);
    leds("after_factory", 8'h84, 40);
  endtask

  initial begin
    // the run takes under a thousand cycles; this bound of 20000 cycles is generous
    #200000;
    failures++;
    report_and_stop();
  end

  initial begin
    t_unconfig();
    t_netwr(1'b0);
    t_netwr(1'b1);
    t_mismatch(1'b0);
    t_mismatch(1'b1);
    t_defaults();
    report_and_stop();
  end
endmodule // rcm_loader_tb_top
